// ===== src/gptb_pkg.sv
// gptb_pkg: shared constants for the second general-purpose timer block
// assumes: 32-bit apb, word-aligned registers
package gptb_pkg;
    localparam int unsigned GPTB_TW = 16;
    // register byte offsets
    localparam logic [7:0] GPTB_CORE_CTRL_OFS = 8'h00;
    localparam logic [7:0] GPTB_AUX_CTRL_OFS  = 8'h04;
    localparam logic [7:0] GPTB_CORE_CNT_OFS  = 8'h08;
    localparam logic [7:0] GPTB_AUX_CNT_OFS   = 8'h0C;
    localparam logic [7:0] GPTB_CAPTURE_RELOAD_REG_OFS    = 8'h10;
    localparam logic [7:0] GPTB_STATUS_OFS    = 8'h14;
    // timer control fields
    localparam int unsigned GPTB_F_RUN   = 0;
    localparam int unsigned GPTB_F_DOWN  = 1;
    localparam int unsigned GPTB_F_EXTDIR = 2;
    localparam int unsigned GPTB_F_MODE  = 3;  // 2 bits
    localparam int unsigned GPTB_F_OUTEN = 5;  // core only
    localparam int unsigned GPTB_F_RLDEN = 6;  // core only
    localparam int unsigned GPTB_F_CAPEN = 7;  // aux only
    localparam int unsigned GPTB_F_CLREN = 8;  // aux only
    localparam int unsigned GPTB_F_CSEL  = 9;  // aux only, 2 bits
    localparam int unsigned GPTB_F_CEDGE = 11; // aux only, 2 bits
    localparam int unsigned GPTB_CTRL_W  = 13;
    localparam logic [GPTB_CTRL_W-1:0] GPTB_CTRL_RST = 13'h0000;
    // status fields
    localparam int unsigned GPTB_S_CAPIRQ = 0;
    localparam int unsigned GPTB_S_LATCH  = 1;
    // count modes
    typedef enum logic [1:0] {
        GPTB_M_CLOCK = 2'b00,  // every pclk
        GPTB_M_EDGE  = 2'b01,  // count-input rising edge
        GPTB_M_GATE  = 2'b11,  // count while count input high
        GPTB_M_LATCH = 2'b10   // toggle latch edges (aux only)
    } gptb_mode_t;
endpackage

// ===== src/gptb_timer.sv
// gptb_timer: one 16-bit up/down timer with load and clear
// assumes: inputs synchronous to pclk, edges computed upstream
`timescale 1ns/1ns
`default_nettype none
module gptb_timer
    import gptb_pkg::*;
#(
    parameter int unsigned W = GPTB_TW
) (
    input  wire logic         pclk,      // clock
    input  wire logic         presetn,   // async reset, low
    input  wire logic         count_en,  // count one step
    input  wire logic         down,      // direction
    input  wire logic         load,      // load value
    input  wire logic [W-1:0] load_val,  // value to load
    input  wire logic         clear,     // clear to zero
    output logic [W-1:0]      cnt_q,     // counter
    output logic              ovf        // wrap event, one cycle
);
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        ovf   = 1'b0;
        if (count_en) begin
            ovf   = down ? (cnt_q == '0) : (cnt_q == '1);
            cnt_d = down ? cnt_q - 1'b1 : cnt_q + 1'b1; // R12
        end
        if (load) begin
            cnt_d = load_val;
        end
        if (clear) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ===== src/gptb_edge.sv
// gptb_edge: rising/falling edge detect on a synchronous level
// assumes: input already synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module gptb_edge (
    input  wire logic pclk,     // clock
    input  wire logic presetn,  // async reset, low
    input  wire logic level,    // level to watch
    output logic      rise,     // rising edge pulse
    output logic      fall      // falling edge pulse
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level;
        rise   = level & ~prev_q;
        fall   = ~level & prev_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end
endmodule
`default_nettype wire

// ===== src/gptb_top.sv
// gptb_top: timer block two with core and auxiliary timers and capture/reload
// assumes: apb master on pclk; pins synchronous to pclk
// Notes on behaviour
// R1: direction by software or external pin
// R2: toggle latch flips on core wrap
// R3: latch clocks aux timer, drives output
// R4: core wraps clock the compare unit
// R5: core wrap optionally reloads from capture register
// R6: capture pin edge latches aux timer
// R7: optionally clear aux after capture
// R8: capture also from block one inputs
// R9: core count/gate input driven externally
// R10: aux count/gate input driven externally
// R11: direction pins driven externally
// R12: 16-bit timers, wrap-around
// R13: capture raises interrupt request flag
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module gptb_top
    import gptb_pkg::*;
(
    input  wire logic        pclk,                      // clock, 50 MHz
    input  wire logic        presetn,                   // async reset, low
    input  wire logic        psel,                      // apb select
    input  wire logic        penable,                   // apb enable
    input  wire logic        pwrite,                    // apb write
    input  wire logic [7:0]  paddr,                     // apb address
    input  wire logic [31:0] pwdata,                    // apb write data
    output logic [31:0]      prdata,                    // apb read data
    output logic             pready,                    // apb ready
    output logic             pslverr,                   // apb error
    input  wire logic        core_count_gate_input,     // core count/gate pin
    input  wire logic        aux_count_gate_input,      // aux count/gate pin
    input  wire logic        core_direction_input,      // core direction pin
    input  wire logic        aux_direction_input,       // aux direction pin
    input  wire logic        capture_input_pin,         // capture pin
    input  wire logic        block_one_count_input,     // block one count input
    input  wire logic        block_one_direction_input, // block one direction input
    output logic             core_toggle_output_pin,    // latch out, gated
    output logic             compare_unit_clk,          // core wrap pulse
    output logic             capture_irq                // capture request flag
);
    logic [GPTB_CTRL_W-1:0] core_ctrl_q, core_ctrl_d;
    logic [GPTB_CTRL_W-1:0] aux_ctrl_q, aux_ctrl_d;
    logic [GPTB_TW-1:0]     capture_reload_reg_q, capture_reload_reg_d;
    logic                   latch_q, latch_d;
    logic                   irq_q, irq_d;
    logic                   ocomp_q, ocomp_d;
    logic                   pout_q, pout_d;
    logic [31:0]            rdata_q, rdata_d;

    logic [GPTB_TW-1:0] core_cnt, aux_cnt;
    logic core_ovf, aux_ovf;
    logic core_step, aux_step;
    logic core_down, aux_down;
    logic core_rise, aux_rise, cap_rise, cap_fall;
    logic b1c_rise, b1c_fall, b1d_rise, b1d_fall;
    logic lat_rise, lat_fall;
    logic cap_evt;
    logic wr, rd;
    logic core_wr, aux_wr, cap_wr;

    gptb_edge u_e_core (.pclk(pclk), .presetn(presetn), .level(core_count_gate_input),
                        .rise(core_rise), .fall());
    gptb_edge u_e_aux  (.pclk(pclk), .presetn(presetn), .level(aux_count_gate_input),
                        .rise(aux_rise), .fall());
    gptb_edge u_e_cap  (.pclk(pclk), .presetn(presetn), .level(capture_input_pin),
                        .rise(cap_rise), .fall(cap_fall));
    gptb_edge u_e_b1c  (.pclk(pclk), .presetn(presetn), .level(block_one_count_input),
                        .rise(b1c_rise), .fall(b1c_fall));
    gptb_edge u_e_b1d  (.pclk(pclk), .presetn(presetn), .level(block_one_direction_input),
                        .rise(b1d_rise), .fall(b1d_fall));
    gptb_edge u_e_lat  (.pclk(pclk), .presetn(presetn), .level(latch_q),
                        .rise(lat_rise), .fall(lat_fall));

    // apb decode: zero wait states
    always_comb begin
        wr      = psel & penable & pwrite;
        rd      = psel & penable & ~pwrite;
        pready  = 1'b1;
        pslverr = psel & penable & (paddr > GPTB_STATUS_OFS || paddr[1:0] != 2'b00);
        core_wr = wr & (paddr == GPTB_CORE_CNT_OFS);
        aux_wr  = wr & (paddr == GPTB_AUX_CNT_OFS);
        cap_wr  = wr & (paddr == GPTB_CAPTURE_RELOAD_REG_OFS);
    end

    // count enables and directions
    always_comb begin
        core_down = core_ctrl_q[GPTB_F_DOWN];
        if (core_ctrl_q[GPTB_F_EXTDIR]) begin
            core_down = core_ctrl_q[GPTB_F_DOWN] ^ core_direction_input; // R1 R11
        end
        aux_down = aux_ctrl_q[GPTB_F_DOWN];
        if (aux_ctrl_q[GPTB_F_EXTDIR]) begin
            aux_down = aux_ctrl_q[GPTB_F_DOWN] ^ aux_direction_input; // R1 R11
        end
        case (gptb_mode_t'(core_ctrl_q[GPTB_F_MODE +: 2]))
            GPTB_M_CLOCK: core_step = 1'b1;
            GPTB_M_EDGE:  core_step = core_rise;             // R9
            GPTB_M_GATE:  core_step = core_count_gate_input; // R9
            default:      core_step = 1'b0;
        endcase
        case (gptb_mode_t'(aux_ctrl_q[GPTB_F_MODE +: 2]))
            GPTB_M_CLOCK: aux_step = 1'b1;
            GPTB_M_EDGE:  aux_step = aux_rise;              // R10
            GPTB_M_GATE:  aux_step = aux_count_gate_input;  // R10
            GPTB_M_LATCH: aux_step = lat_rise | lat_fall;   // R3
            default:      aux_step = 1'b0;
        endcase
        core_step = core_step & core_ctrl_q[GPTB_F_RUN];
        aux_step  = aux_step & aux_ctrl_q[GPTB_F_RUN];
    end

    // capture trigger selection
    always_comb begin
        cap_evt = 1'b0;
        if (aux_ctrl_q[GPTB_F_CAPEN]) begin
            case (aux_ctrl_q[GPTB_F_CSEL +: 2])
                2'b00:   cap_evt = (aux_ctrl_q[GPTB_F_CEDGE] & cap_rise) |
                                   (aux_ctrl_q[GPTB_F_CEDGE + 1] & cap_fall); // R6
                2'b01:   cap_evt = b1c_rise | b1c_fall;                       // R8
                2'b10:   cap_evt = b1d_rise | b1d_fall;                       // R8
                default: cap_evt = b1c_rise | b1c_fall | b1d_rise | b1d_fall; // R8
            endcase
        end
    end

    gptb_timer #(.W(GPTB_TW)) u_core (
        .pclk     (pclk),
        .presetn  (presetn),
        .count_en (core_step),
        .down     (core_down),
        .load     (core_wr | (core_ovf & core_ctrl_q[GPTB_F_RLDEN])), // R5
        .load_val (core_wr ? pwdata[GPTB_TW-1:0] : capture_reload_reg_q),
        .clear    (1'b0),
        .cnt_q    (core_cnt),
        .ovf      (core_ovf)
    );

    gptb_timer #(.W(GPTB_TW)) u_aux (
        .pclk     (pclk),
        .presetn  (presetn),
        .count_en (aux_step),
        .down     (aux_down),
        .load     (aux_wr),
        .load_val (pwdata[GPTB_TW-1:0]),
        .clear    (cap_evt & aux_ctrl_q[GPTB_F_CLREN]), // R7
        .cnt_q    (aux_cnt),
        .ovf      (aux_ovf)
    );

    // registers and flags
    always_comb begin
        core_ctrl_d = core_ctrl_q;
        aux_ctrl_d  = aux_ctrl_q;
        capture_reload_reg_d    = capture_reload_reg_q;
        latch_d     = latch_q ^ core_ovf;  // R2
        irq_d       = irq_q;
        ocomp_d     = core_ovf;            // R4
        pout_d      = latch_q & core_ctrl_q[GPTB_F_OUTEN]; // R3
        rdata_d     = rdata_q;
        if (wr && paddr == GPTB_CORE_CTRL_OFS) begin
            core_ctrl_d = pwdata[GPTB_CTRL_W-1:0];
        end
        if (wr && paddr == GPTB_AUX_CTRL_OFS) begin
            aux_ctrl_d = pwdata[GPTB_CTRL_W-1:0];
        end
        if (cap_wr) begin
            capture_reload_reg_d = pwdata[GPTB_TW-1:0];
        end
        // writing one clears the flag; a capture in the same cycle wins
        if (wr && paddr == GPTB_STATUS_OFS && pwdata[GPTB_S_CAPIRQ]) begin
            irq_d = 1'b0;
        end
        if (cap_evt) begin
            capture_reload_reg_d = aux_cnt; // R6
            irq_d    = 1'b1;    // R13
        end
        if (rd) begin
            case (paddr)
                GPTB_CORE_CTRL_OFS: rdata_d = {19'h00000, core_ctrl_q};
                GPTB_AUX_CTRL_OFS:  rdata_d = {19'h00000, aux_ctrl_q};
                GPTB_CORE_CNT_OFS:  rdata_d = {16'h0000, core_cnt};
                GPTB_AUX_CNT_OFS:   rdata_d = {16'h0000, aux_cnt};
                GPTB_CAPTURE_RELOAD_REG_OFS:    rdata_d = {16'h0000, capture_reload_reg_q};
                GPTB_STATUS_OFS:    rdata_d = {30'h00000000, latch_q, irq_q};
                default:            rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ctrl_q <= GPTB_CTRL_RST;
            aux_ctrl_q  <= GPTB_CTRL_RST;
            capture_reload_reg_q    <= '0;
            latch_q     <= 1'b0;
            irq_q       <= 1'b0;
            ocomp_q     <= 1'b0;
            pout_q      <= 1'b0;
            rdata_q     <= 32'h00000000;
        end else begin
            core_ctrl_q <= core_ctrl_d;
            aux_ctrl_q  <= aux_ctrl_d;
            capture_reload_reg_q    <= capture_reload_reg_d;
            latch_q     <= latch_d;
            irq_q       <= irq_d;
            ocomp_q     <= ocomp_d;
            pout_q      <= pout_d;
            rdata_q     <= rdata_d;
        end
    end

    // read data is combinational over the register snapshot for zero-wait answers
    always_comb begin
        prdata = 32'h00000000;
        if (rd) begin
            case (paddr)
                GPTB_CORE_CTRL_OFS: prdata = {19'h00000, core_ctrl_q};
                GPTB_AUX_CTRL_OFS:  prdata = {19'h00000, aux_ctrl_q};
                GPTB_CORE_CNT_OFS:  prdata = {16'h0000, core_cnt};
                GPTB_AUX_CNT_OFS:   prdata = {16'h0000, aux_cnt};
                GPTB_CAPTURE_RELOAD_REG_OFS:    prdata = {16'h0000, capture_reload_reg_q};
                GPTB_STATUS_OFS:    prdata = {30'h00000000, latch_q, irq_q};
                default:            prdata = 32'h00000000;
            endcase
        end
        core_toggle_output_pin = pout_q;
        compare_unit_clk       = ocomp_q;
        capture_irq            = irq_q;
    end
endmodule
`default_nettype wire

// ===== sim/gptb_chk.sv
// gptb_chk: port-level assertions for timer block two
// assumes: bound to gptb_top, one pclk domain
`timescale 1ns/1ns
`default_nettype none
module gptb_chk
    import gptb_pkg::*;
(
    input wire logic        pclk,                      // clock
    input wire logic        presetn,                   // reset, low
    input wire logic        psel,                      // apb
    input wire logic        penable,                   // apb
    input wire logic        pwrite,                    // apb
    input wire logic [7:0]  paddr,                     // apb
    input wire logic [31:0] pwdata,                    // apb
    input wire logic [31:0] prdata,                    // apb
    input wire logic        pready,                    // apb
    input wire logic        pslverr,                   // apb
    input wire logic        core_count_gate_input,     // pin
    input wire logic        aux_count_gate_input,      // pin
    input wire logic        core_direction_input,      // pin
    input wire logic        aux_direction_input,       // pin
    input wire logic        capture_input_pin,         // pin
    input wire logic        block_one_count_input,     // pin
    input wire logic        block_one_direction_input, // pin
    input wire logic        core_toggle_output_pin,    // out
    input wire logic        compare_unit_clk,          // out
    input wire logic        capture_irq                // out
);
    logic w1c;
    logic ctl_wr;
    assign w1c = psel && penable && pwrite && paddr == GPTB_STATUS_OFS && pwdata[GPTB_S_CAPIRQ];
    assign ctl_wr = psel && penable && pwrite && paddr == GPTB_CORE_CTRL_OFS;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence acc_s;
        psel && penable;
    endsequence
    sequence rd_s(logic [7:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    apb_ready_a: assert property (acc_s |-> pready) else $error("pready low in access");
    bad_addr_a: assert property (acc_s ##0 (paddr > GPTB_STATUS_OFS || paddr[1:0] != 2'h0)
        |-> pslverr && prdata == 32'h0) else $error("bad address not refused");
    idle_quiet_a: assert property (!(psel && penable) |-> !pslverr && prdata == 32'h0) else $error("bus not quiet");
    cnt_width_a: assert property (rd_s(GPTB_CORE_CNT_OFS) or rd_s(GPTB_AUX_CNT_OFS) or rd_s(GPTB_CAPTURE_RELOAD_REG_OFS)
        |-> prdata[31:16] == 16'h0) else $error("counter upper bits set");
    ctrl_width_a: assert property (rd_s(GPTB_CORE_CTRL_OFS) |-> prdata[31:13] == 19'h0) else $error("ctrl upper set");
    status_flag_a: assert property (rd_s(GPTB_STATUS_OFS)
        |-> prdata[0] == capture_irq && prdata[31:2] == 30'h0) else $error("status flag differs from irq");
    toggle_cause_a: assert property ($changed(core_toggle_output_pin) && !$past(ctl_wr) && !$past(ctl_wr, 2)
        |-> compare_unit_clk || $past(compare_unit_clk)) else $error("toggle pin moved without wrap");
    irq_cause_a: assert property ($rose(capture_irq)
        |-> $past(capture_input_pin, 1) != $past(capture_input_pin, 2)
        || $past(block_one_count_input, 1) != $past(block_one_count_input, 2)
        || $past(block_one_direction_input, 1) != $past(block_one_direction_input, 2))
        else $error("irq without trigger edge");
    irq_hold_a: assert property (capture_irq && !w1c |=> capture_irq) else $error("irq dropped");
endmodule
bind gptb_top gptb_chk i_gptb_chk (.*);
`default_nettype wire

// ===== sim/gptb_far_model.sv
// gptb_far_model: port pins, block one inputs and compare unit
// assumes: driven by bench tasks; lines change right after pclk rises
`timescale 1ns/1ns
`default_nettype none
module gptb_far_model (
    input  wire logic pclk,                      // clock
    input  wire logic compare_unit_clk,          // compare clock
    output logic      core_count_gate_input,     // pin
    output logic      aux_count_gate_input,      // pin
    output logic      core_direction_input,      // pin
    output logic      aux_direction_input,       // pin
    output logic      capture_input_pin,         // pin
    output logic      block_one_count_input,     // block one
    output logic      block_one_direction_input  // block one
);
    logic [6:0] pins_q = 7'h00;
    logic [6:0] tog_q  = 7'h00;
    int         cmp_seen = 0;
    assign {block_one_direction_input, block_one_count_input, capture_input_pin, aux_direction_input,
            core_direction_input, aux_count_gate_input, core_count_gate_input} = pins_q;
    // pins move only here, right after the edge that sees a flip request
    always @(posedge pclk) begin
        pins_q <= pins_q ^ tog_q;
        if (compare_unit_clk === 1'b1) begin
            cmp_seen <= cmp_seen + 1;
        end
    end
    // request one flip at the next edge, then hold the level three cycles
    task automatic flip(input int idx);
        tog_q[idx] <= 1'b1;
        @(posedge pclk);
        tog_q[idx] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// testbench: self-checking bench for timer block two
// assumes: gptb_top, gptb_far_model and gptb_chk compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import gptb_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core_count_gate_input, aux_count_gate_input, core_direction_input, aux_direction_input;
    logic        capture_input_pin, block_one_count_input, block_one_direction_input;
    logic        core_toggle_output_pin, compare_unit_clk, capture_irq;
    int          fail_count = 0;
    int          tests_run = 0;
    int          core, aux, cap, latch, irq, cmp, rld, down;
    logic [31:0] rd;
    logic        err;
    gptb_top i_gptb_top (.*);
    gptb_far_model i_gptb_far_model (.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    // one rising count edge on the core input, then the model's view of the step
    task automatic core_step();
        i_gptb_far_model.flip(0);
        i_gptb_far_model.flip(0);
        if ((!down && core == 'hFFFF) || (down && core == 0)) begin
            core = rld ? cap : (down ? 'hFFFF : 0);
            latch ^= 1;
            cmp++;
            aux = (aux + 1) & 'hFFFF;
        end else begin
            core = (down ? core - 1 : core + 1) & 'hFFFF;
        end
        rdchk(GPTB_CORE_CNT_OFS, core, "core count");
        chk("toggle pin", {31'h0, core_toggle_output_pin}, latch);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {core, aux, cap, latch, irq, cmp, rld, down} = '0;
        void'($urandom(79148));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 'h14; a += 4) begin
            rdchk(8'(a), 32'h0, "reset value");
        end
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        chk("refused write", {31'h0, err}, 32'h1);
        rdchk(8'h06, 32'h0, "misaligned read");
        $display("test registers done");
        apb(1'b1, GPTB_AUX_CTRL_OFS, 32'h11);
        core = 'hFFFF - ($urandom % 3);
        apb(1'b1, GPTB_CORE_CNT_OFS, core);
        apb(1'b1, GPTB_CORE_CTRL_OFS, 32'h2D);
        for (int i = 0; i < 13; i++) begin
            if (i == 5) begin
                i_gptb_far_model.flip(2);
                down = 1;
            end
            core_step();
        end
        rdchk(GPTB_AUX_CNT_OFS, aux, "aux from latch");
        rdchk(GPTB_STATUS_OFS, latch << 1, "toggle latch");
        chk("compare clocks", i_gptb_far_model.cmp_seen, cmp);
        $display("test count and wrap done");
        cap = $urandom & 'hFFFF;
        apb(1'b1, GPTB_CAPTURE_RELOAD_REG_OFS, cap);
        apb(1'b1, GPTB_CORE_CTRL_OFS, 32'h6F);
        {rld, down, core} = {32'd1, 32'd0, 32'hFFFE};
        apb(1'b1, GPTB_CORE_CNT_OFS, core);
        repeat (3) core_step();
        chk("compare clocks", i_gptb_far_model.cmp_seen, cmp);
        $display("test reload done");
        apb(1'b1, GPTB_AUX_CTRL_OFS, 32'h09);
        repeat (3) begin
            i_gptb_far_model.flip(1);
            i_gptb_far_model.flip(1);
            aux = (aux + 1) & 'hFFFF;
        end
        apb(1'b1, GPTB_AUX_CTRL_OFS, 32'h0D);
        i_gptb_far_model.flip(3);
        repeat (2) begin
            i_gptb_far_model.flip(1);
            i_gptb_far_model.flip(1);
            aux = (aux - 1) & 'hFFFF;
        end
        rdchk(GPTB_AUX_CNT_OFS, aux, "aux external down");
        apb(1'b1, GPTB_AUX_CTRL_OFS, 32'h991);
        i_gptb_far_model.flip(4);
        i_gptb_far_model.flip(4);
        {cap, aux, irq} = {aux, 32'd0, 32'd1};
        rdchk(GPTB_CAPTURE_RELOAD_REG_OFS, cap, "capture value");
        rdchk(GPTB_AUX_CNT_OFS, aux, "aux cleared");
        chk("capture irq", {31'h0, capture_irq}, irq);
        apb(1'b1, GPTB_STATUS_OFS, 32'h1);
        irq = 0;
        rdchk(GPTB_STATUS_OFS, latch << 1, "irq cleared");
        for (int s = 1; s < 4; s++) begin
            aux = $urandom & 'hFFFF;
            apb(1'b1, GPTB_AUX_CTRL_OFS, 32'h91 | (s << 9));
            apb(1'b1, GPTB_AUX_CNT_OFS, aux);
            i_gptb_far_model.flip(s == 2 ? 6 : 5);
            rdchk(GPTB_CAPTURE_RELOAD_REG_OFS, aux, "block one capture");
            chk("capture irq", {31'h0, capture_irq}, 32'h1);
        end
        $display("test capture done");
        finish_test();
    end
endmodule
`default_nettype wire
